// File: rtl/bsa_defines.svh
// Constants of the bus state analyzer: capture layout, depths, timing.
// Assumes inclusion by bare name from the analyzer design files.
`ifndef BSA_DEFINES_SVH
`define BSA_DEFINES_SVH

// Capture buffer shape
`define BSA_DEPTH 128
`define BSA_AW 7
`define BSA_WORD_W 32
`define BSA_POST_STATES 7'd64
`define BSA_FIFO_DEPTH 8

// Field positions inside one captured bus state
`define BSA_F_ADDR_LO 0
`define BSA_F_DATA_LO 16
`define BSA_F_VMA 24
`define BSA_F_RW 25
`define BSA_F_IRQ 26
`define BSA_F_NMI 27
`define BSA_F_USER_LO 28

// Reset values
`define BSA_RW_IDLE 1'b1
`define BSA_PTR_RST 7'h00

// Timing: system clock and phase-2 clock range
`define BSA_CLK_PERIOD_NS 50
`define BSA_PHI2_MIN_KHZ 100
`define BSA_PHI2_MAX_KHZ 1000
`define BSA_PHI2_MAX_PERIOD_NS (1000000 / `BSA_PHI2_MIN_KHZ)
`define BSA_PHI2_LOST_CYC (`BSA_PHI2_MAX_PERIOD_NS / `BSA_CLK_PERIOD_NS)

`endif

// File: rtl/bsa_pkg.sv
// Types shared by the bus state analyzer design files.
// Assumes nothing beyond a SystemVerilog compiler.
package bsa_pkg;

    // Operating modes as set on the mode selector
    typedef enum logic [2:0] {
        MODE_RUN = 3'b000,
        MODE_STEP = 3'b001,
        MODE_STANDBY = 3'b010,
        MODE_RDWR = 3'b011,
        MODE_TRACE = 3'b100,
        MODE_WINDOW = 3'b101
    } bsa_mode_t;

    // Raw selector code; 3'b110 and 3'b111 are illegal
    typedef logic [2:0] bsa_mode_sel_t;

    // Address qualifier chosen by configuration
    typedef enum logic [1:0] {
        QUAL_VALID = 2'b00,
        QUAL_USER = 2'b01,
        QUAL_EXEC = 2'b10,
        QUAL_PAGE = 2'b11
    } bsa_qual_t;

    // Memory access sequencer states
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_DRIVE = 2'b01
    } bsa_acc_t;

endpackage

// File: rtl/bsa_trace_mem.sv
// Capture store of the bus state analyzer: one write port, one read port.
// Assumes a single clock; read data appears one clock after the address.
`timescale 1ns/100ps
`include "bsa_defines.svh"

module bsa_trace_mem (
    input wire logic clk,
    input wire logic we,
    input wire logic [`BSA_AW-1:0] waddr,
    input wire logic [`BSA_WORD_W-1:0] wdata,
    input wire logic [`BSA_AW-1:0] raddr,
    output logic [`BSA_WORD_W-1:0] rdata
);

    logic [`BSA_WORD_W-1:0] mem [0:`BSA_DEPTH-1];

    // Contents carry no reset; only the pointers around them do
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Registered read keeps the array mappable onto block memory
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end

endmodule

// File: rtl/bsa_fifo.sv
// Small first-in first-out queue with a registered output stage.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps

module bsa_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    // Output stage refills whenever it is empty or being taken
    assign push = in_valid & in_ready;
    assign pop = (cnt_r != '0) & (~out_valid | out_ready);

    always_comb begin
        cnt_nxt = cnt_r;
        if (push & ~pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop & ~push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    // Pointers, fill count and registered ready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            in_ready <= cnt_nxt < (AW+1)'(DEPTH);
        end
    end

    // Output register; a stalled reader holds it and so fills the queue
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (pop) begin
            out_valid <= 1'b1;
            out_data <= mem[rp_r];
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

endmodule

// File: rtl/bsa_top.sv
// Bus state analyzer: compare unit, capture buffer, processor halt and
// memory access control, panel indicators and trace readout queue.
// Assumes all inputs synchronous to sys_clk, phase-2 much slower than it.
`timescale 1ns/100ps
`include "bsa_defines.svh"

module bsa_top #(
    parameter bit DATA_ACTIVE_HIGH = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic phi2,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] data_in,
    input wire logic rw_in,
    input wire logic valid_addr_qual,
    input wire logic user_addr_qual,
    input wire logic exec_addr_qual,
    input wire logic page_select_qual,
    input wire logic irq_n,
    input wire logic nmi_n,
    input wire logic bus_avail,
    input wire logic [3:0] user_in,
    output logic [15:0] addr_out,
    output logic addr_oe,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic rw_out,
    output logic rw_oe,
    output logic vma_out,
    output logic vma_oe,
    output logic halt_n,
    input wire bsa_pkg::bsa_mode_sel_t mode_sel,
    input wire bsa_pkg::bsa_qual_t qual_sel,
    input wire logic [15:0] addr_sw,
    input wire logic [7:0] data_sw,
    input wire logic [15:0] cmp_en_addr,
    input wire logic [7:0] cmp_en_data,
    input wire logic step_req,
    input wire logic access_go,
    input wire logic access_write,
    input wire logic rd_req,
    input wire logic [6:0] rd_idx,
    output logic rd_req_ready,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [31:0] rd_data,
    output logic cmp_strobe,
    output logic led_halted,
    output logic led_rw,
    output logic led_vma,
    output logic led_irq,
    output logic led_nmi,
    output logic [3:0] led_user,
    output logic [15:0] disp_addr,
    output logic [7:0] disp_data,
    output logic [7:0] access_data,
    output logic access_done,
    output logic trace_frozen,
    output logic phi2_lost
);
    import bsa_pkg::*;

    logic phi2_d_r;
    logic phi2_fall;
    logic phi2_edge;
    logic [7:0] phi2_cnt_r;
    bsa_mode_t mode_nxt;
    bsa_mode_t mode_r;
    logic mode_chg;
    logic [7:0] data_lv;
    logic qual_ok;
    logic cmp_hit;
    logic [`BSA_WORD_W-1:0] cap_word;
    logic rec_we;
    logic [`BSA_AW-1:0] wptr_r;
    logic trig_r;
    logic [6:0] post_r;
    logic frozen_last;
    logic halt_req_r;
    logic step_rel_r;
    logic own;
    bsa_acc_t acc_r;
    logic acc_pend_r;
    logic acc_wr_r;
    logic wr_drive;
    logic rd_take;
    logic rd_pend_r;
    logic [`BSA_AW-1:0] rd_addr;
    logic [`BSA_WORD_W-1:0] mem_rdata;
    logic fifo_in_ready;

    // Phase-2 falls mark the end of each bus cycle; sampling point
    assign phi2_fall = phi2_d_r & ~phi2;
    assign phi2_edge = phi2_d_r ^ phi2;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phi2_d_r <= 1'b0;
        end else begin
            phi2_d_r <= phi2;
        end
    end

    // No edge of either sense for 200 clocks (10 us, below 50 kHz at even duty): flag it
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phi2_cnt_r <= 8'h00;
            phi2_lost <= 1'b0;
        end else if (phi2_edge) begin
            phi2_cnt_r <= 8'h00;
            phi2_lost <= 1'b0;
        end else if (phi2_cnt_r == 8'(`BSA_PHI2_LOST_CYC)) begin
            phi2_lost <= 1'b1;
        end else begin
            phi2_cnt_r <= phi2_cnt_r + 8'h01;
        end
    end

    // Illegal selector codes fall back to run, the harmless mode
    always_comb begin
        case (mode_sel)
            3'b000: mode_nxt = MODE_RUN;
            3'b001: mode_nxt = MODE_STEP;
            3'b010: mode_nxt = MODE_STANDBY;
            3'b011: mode_nxt = MODE_RDWR;
            3'b100: mode_nxt = MODE_TRACE;
            3'b101: mode_nxt = MODE_WINDOW;
            default: mode_nxt = MODE_RUN;
        endcase
    end

    assign mode_chg = mode_nxt != mode_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_r <= MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Data pins are low-true unless the build selects high-true
    assign data_lv = DATA_ACTIVE_HIGH ? data_in : ~data_in;

    // Qualifier choice; the user qualifier already excludes monitor space
    always_comb begin
        unique case (qual_sel)
            QUAL_VALID: qual_ok = valid_addr_qual;
            QUAL_USER: qual_ok = user_addr_qual;
            QUAL_EXEC: qual_ok = exec_addr_qual;
            QUAL_PAGE: qual_ok = page_select_qual;
        endcase
    end

    // Disabled lines always match; own accesses never trigger
    assign cmp_hit = phi2_fall & (mode_r != MODE_RUN) & qual_ok & ~own
        & (&(~cmp_en_addr | ~(addr_in ^ addr_sw)))
        & (&(~cmp_en_data | ~(data_lv ^ data_sw)));

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmp_strobe <= 1'b0;
        end else begin
            cmp_strobe <= cmp_hit;
        end
    end

    // One bus state per phase-2 cycle
    assign cap_word = {user_in, nmi_n, irq_n, rw_in, valid_addr_qual,
                       data_lv, addr_in};
    assign rec_we = phi2_fall & ~trace_frozen
        & ((mode_r == MODE_TRACE) | (mode_r == MODE_WINDOW));
    assign frozen_last = rec_we & trig_r & (post_r == `BSA_POST_STATES - 7'd1);

    // Trigger and post-count; entering any mode re-arms the capture
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wptr_r <= `BSA_PTR_RST;
            trig_r <= 1'b0;
            post_r <= 7'h00;
            trace_frozen <= 1'b0;
        end else if (mode_chg) begin
            trig_r <= 1'b0;
            post_r <= 7'h00;
            trace_frozen <= 1'b0;
        end else if (rec_we) begin
            wptr_r <= wptr_r + 7'h01;
            if (trig_r) begin
                post_r <= post_r + 7'h01;
                trace_frozen <= frozen_last;
            end else if (cmp_hit) begin
                trig_r <= 1'b1;
            end
        end
    end

    bsa_trace_mem u_mem (
        .clk(sys_clk),
        .we(rec_we),
        .waddr(wptr_r),
        .wdata(cap_word),
        .raddr(rd_addr),
        .rdata(mem_rdata)
    );

    // Halt request per mode; the processor answers through bus_avail
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            halt_req_r <= 1'b0;
            step_rel_r <= 1'b0;
        end else begin
            unique case (mode_r)
                MODE_RUN: begin
                    halt_req_r <= 1'b0;
                    step_rel_r <= 1'b0;
                end
                MODE_STEP: begin
                    if (cmp_hit & ~halt_req_r & ~step_rel_r) begin
                        halt_req_r <= 1'b1;
                    end else if (step_req & halt_req_r & bus_avail) begin
                        halt_req_r <= 1'b0;
                        step_rel_r <= 1'b1;
                    end else if (step_rel_r & ~bus_avail) begin
                        halt_req_r <= 1'b1;
                        step_rel_r <= 1'b0;
                    end
                end
                MODE_STANDBY: begin
                    halt_req_r <= halt_req_r;
                    step_rel_r <= 1'b0;
                end
                MODE_RDWR: begin
                    if (cmp_hit) begin
                        halt_req_r <= 1'b1;
                    end
                end
                MODE_TRACE: begin
                    if (frozen_last) begin
                        halt_req_r <= 1'b1;
                    end
                end
                MODE_WINDOW: begin
                    halt_req_r <= 1'b0;
                    step_rel_r <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            halt_n <= 1'b1;
        end else begin
            halt_n <= ~halt_req_r;
        end
    end

    // Bus is ours only once the processor confirms it floated the lines
    assign own = (mode_r == MODE_RDWR) & halt_req_r & bus_avail;
    assign wr_drive = own & (acc_r == ACC_DRIVE) & acc_wr_r & ~phi2_fall;

    // Access sequencer: one full phase-2 cycle, fall to fall
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_r <= ACC_IDLE;
            acc_pend_r <= 1'b0;
            acc_wr_r <= 1'b0;
            access_done <= 1'b0;
            access_data <= 8'h00;
        end else begin
            access_done <= 1'b0;
            if (!own) begin
                acc_r <= ACC_IDLE;
                acc_pend_r <= 1'b0;
            end else begin
                if (access_go) begin
                    acc_pend_r <= 1'b1;
                    acc_wr_r <= access_write;
                end
                unique case (acc_r)
                    ACC_IDLE: begin
                        if (acc_pend_r & phi2_fall) begin
                            acc_r <= ACC_DRIVE;
                            acc_pend_r <= access_go;
                        end
                    end
                    ACC_DRIVE: begin
                        if (phi2_fall) begin
                            acc_r <= ACC_IDLE;
                            access_done <= 1'b1;
                            access_data <= data_lv;
                        end
                    end
                endcase
            end
        end
    end

    // Pin drivers: address, qualifier and direction while owned
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            addr_out <= 16'h0000;
            addr_oe <= 1'b0;
            vma_out <= 1'b0;
            vma_oe <= 1'b0;
            rw_out <= `BSA_RW_IDLE;
            rw_oe <= 1'b0;
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            addr_out <= addr_sw;
            addr_oe <= own;
            vma_out <= own;
            vma_oe <= own;
            rw_out <= ~wr_drive;
            rw_oe <= own;
            data_out <= DATA_ACTIVE_HIGH ? data_sw : ~data_sw;
            data_oe <= wr_drive;
        end
    end

    // Panel lamps follow the last sampled cycle; halt lamp is live
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            led_halted <= 1'b0;
            led_rw <= 1'b0;
            led_vma <= 1'b0;
            led_irq <= 1'b0;
            led_nmi <= 1'b0;
            led_user <= 4'h0;
            disp_addr <= 16'h0000;
            disp_data <= 8'h00;
        end else begin
            led_halted <= bus_avail;
            if (phi2_fall) begin
                led_rw <= rw_in;
                led_vma <= valid_addr_qual;
                led_irq <= ~irq_n;
                led_nmi <= ~nmi_n;
                led_user <= user_in;
                disp_addr <= addr_in;
                disp_data <= data_lv;
            end
        end
    end

    // Readout: index 0 is the oldest state, 63 the match once frozen
    assign rd_take = rd_req & rd_req_ready;
    assign rd_addr = wptr_r + rd_idx;

    // One read in flight keeps the queue from overflowing
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_pend_r <= 1'b0;
            rd_req_ready <= 1'b0;
        end else begin
            rd_pend_r <= rd_take;
            rd_req_ready <= ~rd_take & ~rd_pend_r & fifo_in_ready;
        end
    end

    bsa_fifo #(
        .W(`BSA_WORD_W),
        .DEPTH(`BSA_FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(rd_pend_r),
        .in_ready(fifo_in_ready),
        .in_data(mem_rdata),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );

endmodule

// File: verification/bsa_top_chk_sva.sv
// Port-level timing checker for the bus state analyzer top.
// Assumes binding onto bsa_top; one clock, synchronous active-low reset.
`timescale 1ns/100ps

module bsa_top_chk (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic phi2,
    input wire logic bus_avail,
    input wire bsa_pkg::bsa_mode_sel_t mode_sel,
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic rw_out,
    input wire logic rw_oe,
    input wire logic vma_out,
    input wire logic vma_oe,
    input wire logic halt_n,
    input wire logic rd_req,
    input wire logic rd_req_ready,
    input wire logic cmp_strobe,
    input wire logic led_halted,
    input wire logic access_done,
    input wire logic trace_frozen
);
    import bsa_pkg::*;
    // Everything here lives in the one system clock domain
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_strobe_fall: assert property (
        cmp_strobe |-> !$past(phi2) && $past(phi2, 2))
        else $error("compare strobe away from a phase-2 fall");
    chk_run_quiet: assert property (
        (mode_sel == MODE_RUN) [*3] |-> !cmp_strobe)
        else $error("compare strobe in run mode");
    chk_run_free: assert property (
        (mode_sel == MODE_RUN) [*4] |-> halt_n)
        else $error("processor halted in run mode");
    chk_window_runs: assert property (
        (mode_sel == MODE_WINDOW) [*4] |-> halt_n)
        else $error("processor halted in window mode");
    chk_trace_halt: assert property (
        $rose(trace_frozen) && mode_sel == MODE_TRACE |-> ##[0:2] !halt_n)
        else $error("trace freeze without halt");
    chk_vma_owned: assert property (
        vma_oe |-> vma_out && addr_oe && rw_oe)
        else $error("valid address not driven high while owning");
    chk_own_cause: assert property (
        $rose(addr_oe) |-> $past(bus_avail) && !$past(halt_n))
        else $error("bus taken while processor not halted");
    chk_write_drive: assert property (
        data_oe |-> !rw_out && rw_oe && addr_oe)
        else $error("data driven outside a write cycle");
    chk_rw_rest: assert property (
        !rw_oe |-> rw_out)
        else $error("read/write not resting in read");
    chk_done_clean: assert property (
        access_done |-> rw_out && !data_oe ##1 !access_done)
        else $error("access end not clean");
    chk_led_halted: assert property (
        $rose(bus_avail) |-> ##[1:40] led_halted)
        else $error("halted indicator not shown");
    chk_rd_gap: assert property (
        rd_req && rd_req_ready |=> !rd_req_ready [*2])
        else $error("readout taken too soon");
endmodule

bind bsa_top bsa_top_chk u_chk (.sys_clk, .rst_n, .phi2, .bus_avail,
    .mode_sel, .addr_oe, .data_oe, .rw_out, .rw_oe, .vma_out, .vma_oe,
    .halt_n, .rd_req, .rd_req_ready, .cmp_strobe, .led_halted,
    .access_done, .trace_frozen);

// File: verification/bsa_cpu_model.sv
// Behavioural processor bus with 256 bytes of memory behind it.
// Assumes bsa_top drives halt and the owned-bus outputs; one clock.
`timescale 1ns/100ps

module bsa_cpu_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic halt_n,
    input wire logic [15:0] addr_out,
    input wire logic addr_oe,
    input wire logic [7:0] data_out,
    input wire logic data_oe,
    input wire logic rw_out,
    input wire logic rw_oe,
    input wire logic vma_out,
    input wire logic vma_oe,
    output logic phi2,
    output logic [15:0] addr_in,
    output logic [7:0] data_in,
    output logic rw_in,
    output logic valid_addr_qual,
    output logic user_addr_qual,
    output logic exec_addr_qual,
    output logic page_select_qual,
    output logic bus_avail
);
    logic [7:0] mem [256];
    logic [4:0] cnt;
    logic [15:0] pc;

    // Phase-2 at 1 MHz: twenty clocks, high in the second half
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            pc <= 16'h0100;
            bus_avail <= 1'b0;
        end else begin
            cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
            // Address moves on the rise so it is steady across the fall
            if (cnt == 5'h09 && !bus_avail)
                pc <= pc + 16'h0001;
            if (cnt == 5'h13) begin
                bus_avail <= !halt_n;
                if (data_oe && !rw_out && vma_oe && vma_out)
                    mem[addr_out[7:0]] <= ~data_out;
            end
        end
    end

    // Released data and direction lines show a moving pattern, the address the inverse of pc; never the last value
    assign phi2 = (cnt >= 5'h0a);
    assign addr_in = !bus_avail ? pc : (addr_oe ? addr_out : ~pc);
    assign data_in = !bus_avail ? ~mem[pc[7:0]] : data_oe ? data_out :
        (rw_oe && vma_oe) ? ~mem[addr_out[7:0]] : {cnt, cnt[2:0]};
    assign rw_in = !bus_avail ? 1'b1 : (rw_oe ? rw_out : cnt[0]);
    assign valid_addr_qual = !bus_avail || (vma_oe && vma_out);
    assign user_addr_qual = !bus_avail && !pc[15];
    assign exec_addr_qual = !bus_avail && pc[15];
    assign page_select_qual = !bus_avail;
endmodule

// File: verification/bsa_top_test.sv
// Self-checking bench for bsa_top with a behavioural processor beside it.
// Assumes the checker is bound in separately; 20 MHz clock.
`timescale 1ns/100ps

module bsa_top_test;
    import bsa_pkg::*;
    logic sys_clk, rst_n, phi2, rw_in, irq_n, nmi_n, bus_avail;
    logic valid_addr_qual, user_addr_qual, exec_addr_qual, page_select_qual;
    logic addr_oe, data_oe, rw_out, rw_oe, vma_out, vma_oe, halt_n;
    logic step_req, access_go, access_write, rd_req, rd_req_ready;
    logic rd_valid, rd_ready, cmp_strobe, access_done, trace_frozen;
    logic [15:0] addr_in, addr_out, addr_sw, cmp_en_addr, tgt, pc0;
    logic [7:0] data_in, data_out, data_sw, cmp_en_data, access_data, a;
    logic [3:0] user_in;
    logic [6:0] rd_idx;
    logic [31:0] rd_data;
    bsa_mode_sel_t mode_sel;
    bsa_qual_t qual_sel;
    int n_errors = 0, checked = 0, strobes = 0;

    bsa_top dut (.sys_clk, .rst_n, .phi2, .addr_in, .data_in, .rw_in,
        .valid_addr_qual, .user_addr_qual, .exec_addr_qual,
        .page_select_qual, .irq_n, .nmi_n, .bus_avail, .user_in,
        .addr_out, .addr_oe, .data_out, .data_oe, .rw_out, .rw_oe,
        .vma_out, .vma_oe, .halt_n, .mode_sel, .qual_sel, .addr_sw,
        .data_sw, .cmp_en_addr, .cmp_en_data, .step_req, .access_go,
        .access_write, .rd_req, .rd_idx, .rd_req_ready, .rd_valid,
        .rd_ready, .rd_data, .cmp_strobe, .led_halted(), .led_rw(),
        .led_vma(), .led_irq(), .led_nmi(), .led_user(), .disp_addr(),
        .disp_data(), .access_data, .access_done, .trace_frozen,
        .phi2_lost());
    bsa_cpu_model u_cpu (.sys_clk, .rst_n, .halt_n, .addr_out, .addr_oe,
        .data_out, .data_oe, .rw_out, .rw_oe, .vma_out, .vma_oe, .phi2,
        .addr_in, .data_in, .rw_in, .valid_addr_qual, .user_addr_qual,
        .exec_addr_qual, .page_select_qual, .bus_avail);

    task print_verdict;
        if (n_errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task check_val(input string nm, input logic [31:0] e,
                   input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return halt_n;
            1: return !halt_n;
            2: return trace_frozen;
            3: return access_done;
            4: return bus_avail;
            5: return !bus_avail;
            6: return addr_oe;
            default: return rd_valid;
        endcase
    endfunction

    // Bounded wait on a design flag, sampled where it is settled
    task wait_on(input string nm, input int s, input int lim);
        int k;
        k = 0;
        while (sig(s) !== 1'b1 && k < lim) begin
            @(negedge sys_clk);
            k++;
        end
        check_val(nm, 1, {31'h0, sig(s)});
    endtask

    // Expected word at a frozen index: match state sits at 63
    function automatic logic [23:0] exp_entry(input int idx);
        logic [15:0] ea;
        ea = tgt - 16'd63 + 16'(idx % 128);
        return {u_cpu.mem[ea[7:0]], ea};
    endfunction

    task arm(input bsa_mode_sel_t m, input int ofs);
        @(negedge sys_clk);
        tgt = addr_in + 16'(ofs);
        mode_sel = m;
        addr_sw = tgt;
        data_sw = u_cpu.mem[tgt[7:0]];
        cmp_en_data = 8'($urandom);
    endtask

    task access(input logic wr, input logic [7:0] ad);
        @(negedge sys_clk);
        addr_sw = {8'h00, ad};
        access_write = wr;
        data_sw = 8'($urandom);
        @(negedge sys_clk);
        access_go = 1;
        @(negedge sys_clk);
        access_go = 0;
        wait_on("access_done", 3, 80);
        if (wr)
            check_val("mem", data_sw, u_cpu.mem[ad]);
        else
            check_val("access_data", u_cpu.mem[ad], access_data);
    endtask

    // Fill the readout queue with the reader stalled, then drain it
    task read_burst(input int base);
        int n, t, k;
        rd_ready = 0;
        rd_req = 1;
        for (n = 0; n < 10; n++) begin
            rd_idx = 7'(base + n);
            t = 0;
            while (rd_req_ready !== 1'b1 && t < 8) begin
                @(negedge sys_clk);
                t++;
            end
            if (rd_req_ready !== 1'b1)
                break;
            @(negedge sys_clk);
        end
        rd_req = 0;
        check_val("fifo full", 1, 32'(n >= 8 && n <= 9));
        rd_ready = 1;
        for (k = 0; k < n; k++) begin
            wait_on("rd_valid", 7, 10);
            check_val("entry", exp_entry(base + k), rd_data[23:0]);
            @(negedge sys_clk);
        end
        rd_ready = 0;
        repeat (4) @(negedge sys_clk);
        check_val("drained", 0, {31'h0, rd_valid});
    endtask

    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end

    // Watchdog: the whole sequence needs well under 10000 clocks
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_errors++;
        print_verdict;
    end

    // Interrupt and user lines wander at random throughout
    always @(negedge sys_clk)
        {irq_n, nmi_n, user_in} = 6'($urandom);

    always @(negedge sys_clk)
        if (cmp_strobe === 1'b1)
            strobes++;

    initial begin
        void'($urandom(32'h8a9805fb));
        for (int i = 0; i < 256; i++)
            u_cpu.mem[i] = 8'($urandom);
        {rst_n, step_req, access_go, access_write, rd_req, rd_ready} = 0;
        {irq_n, nmi_n, user_in, rd_idx, addr_sw, data_sw} = 0;
        mode_sel = MODE_RUN;
        qual_sel = QUAL_VALID;
        cmp_en_addr = 16'hffff;
        cmp_en_data = 8'hff;
        repeat (5) @(negedge sys_clk);
        check_val("halt_n", 1, {31'h0, halt_n});
        check_val("rw_out", 1, {31'h0, rw_out});
        rst_n = 1;
        arm(MODE_RUN, 2);
        repeat (80) @(negedge sys_clk);
        check_val("strobes", 0, strobes);
        arm(MODE_STEP, 3);
        wait_on("halt", 1, 200);
        wait_on("bus_avail", 4, 60);
        check_val("strobes", 1, strobes);
        pc0 = u_cpu.pc;
        step_req = 1;
        @(negedge sys_clk);
        step_req = 0;
        wait_on("bus free", 5, 60);
        wait_on("bus_avail", 4, 60);
        check_val("pc", pc0 + 16'h1, u_cpu.pc);
        mode_sel = MODE_STANDBY;
        repeat (60) @(negedge sys_clk);
        check_val("held", 0, {31'h0, halt_n});
        mode_sel = MODE_RUN;
        wait_on("bus free", 5, 80);
        arm(MODE_RDWR, 3);
        wait_on("owned", 6, 200);
        repeat (3) begin
            a = 8'($urandom);
            access(1'b1, a);
            access(1'b0, a);
            access(1'b0, a + 8'h01);
        end
        mode_sel = MODE_RUN;
        wait_on("released", 0, 60);
        wait_on("bus free", 5, 60);
        arm(MODE_TRACE, 70);
        wait_on("frozen", 2, 3200);
        wait_on("halt", 1, 5);
        read_burst(60);
        mode_sel = MODE_RUN;
        wait_on("bus free", 5, 80);
        arm(MODE_WINDOW, 70);
        wait_on("frozen", 2, 3200);
        repeat (40) @(negedge sys_clk);
        check_val("running", 0, {31'h0, bus_avail});
        read_burst(120);
        print_verdict;
    end
endmodule
